/* energy_detect_power_control.sv */
`timescale 1ns/1ps
`default_nettype none

module energy_detect_power_control
    import energy_detect_pkg::*;
#(
    parameter logic [IDLE_W-1:0] IDLE_RESET_CYCLES = IDLE_W'(IDLE_RESET_CYC)
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Management register access
    input wire reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    // Line event inputs from the analog detector
    input wire line_events_t line_ev,
    // Power sequencing and pulse transmit
    output logic power_up_start,
    output logic power_down_start,
    output logic detect_pulse_tx
);

    energy_detect_control_t ctrl;
    logic [3:0] data_cnt;
    logic [3:0] err_cnt;
    logic [IDLE_W-1:0] idle_cnt;
    logic [2:0] burst_left;
    logic [7:0] gap_cnt;
    logic sel;
    logic wr_hit;
    logic rd_hit;
    logic idle_expired;
    logic go_up;
    logic go_down;
    energy_detect_control_t wr_view;

    // Viewing the write data through the register layout keeps field positions in one place.
    assign wr_view = energy_detect_control_t'(reg_req.wdata);
    assign sel = (reg_req.addr == EDC_ADDR);
    assign wr_hit = reg_req.wr && sel;
    assign rd_hit = reg_req.rd && sel;
    assign idle_expired = (idle_cnt >= IDLE_RESET_CYCLES);

    // Manual toggle takes priority over the automatic decisions in the same cycle.
    always_comb
    begin
        go_up = 1'b0;
        go_down = 1'b0;
        if (ctrl.manual)
        begin
            go_up = !ctrl.pwr_state;
            go_down = ctrl.pwr_state;
        end
        else if (ctrl.enable)
        begin
            go_up = !ctrl.pwr_state && ctrl.auto_wake && (data_cnt >= ctrl.data_thresh);
            go_down = ctrl.pwr_state && ctrl.auto_sleep && !line_ev.energy_present;
        end
    end

    // Writable fields and the self-clearing manual command.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl.enable <= RST_ENABLE;
            ctrl.auto_wake <= RST_AUTO_WAKE;
            ctrl.auto_sleep <= RST_AUTO_SLEEP;
            ctrl.manual <= 1'b0;
            ctrl.burst_dis <= RST_BURST_DIS;
            ctrl.err_thresh <= RST_ERR_THRESH;
            ctrl.data_thresh <= RST_DATA_THRESH;
        end
        else if (wr_hit)
        begin
            ctrl.enable <= reg_req.wdata[BIT_ENABLE];
            ctrl.auto_wake <= reg_req.wdata[BIT_AUTO_WAKE];
            ctrl.auto_sleep <= reg_req.wdata[BIT_AUTO_SLEEP];
            ctrl.manual <= reg_req.wdata[BIT_MANUAL];
            ctrl.burst_dis <= reg_req.wdata[BIT_BURST_DIS];
            ctrl.err_thresh <= wr_view.err_thresh;
            ctrl.data_thresh <= wr_view.data_thresh;
        end
        else
        begin
            ctrl.manual <= 1'b0;
        end
    end

    // Power state moves in the same edge that the start pulse is issued.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl.pwr_state <= 1'b0;
            power_up_start <= 1'b0;
            power_down_start <= 1'b0;
        end
        else
        begin
            power_up_start <= go_up;
            power_down_start <= go_down;
            if (go_up || go_down)
            begin
                ctrl.pwr_state <= go_up;
            end
        end
    end

    // Saturating event counters, cleared by quiet time or a power transition.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            data_cnt <= 4'h0;
            err_cnt <= 4'h0;
            idle_cnt <= '0;
        end
        else if (!ctrl.enable)
        begin
            data_cnt <= 4'h0;
            err_cnt <= 4'h0;
            idle_cnt <= '0;
        end
        else
        begin
            if (line_ev.data_event)
            begin
                idle_cnt <= '0;
            end
            else if (!idle_expired)
            begin
                idle_cnt <= idle_cnt + IDLE_W'(1);
            end
            if ((idle_expired && !line_ev.data_event) || go_up || go_down)
            begin
                data_cnt <= 4'h0;
                err_cnt <= 4'h0;
            end
            else
            begin
                if (line_ev.data_event && data_cnt != COUNT_MAX)
                begin
                    data_cnt <= data_cnt + 4'h1;
                end
                if (line_ev.error_event && err_cnt != COUNT_MAX)
                begin
                    err_cnt <= err_cnt + 4'h1;
                end
            end
        end
    end

    // Sticky flags; a new hit in the read cycle survives the clear.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl.err_hit <= 1'b0;
            ctrl.data_hit <= 1'b0;
        end
        else
        begin
            if (ctrl.enable && err_cnt >= ctrl.err_thresh)
            begin
                ctrl.err_hit <= 1'b1;
            end
            else if (rd_hit)
            begin
                ctrl.err_hit <= 1'b0;
            end
            if (ctrl.enable && data_cnt >= ctrl.data_thresh)
            begin
                ctrl.data_hit <= 1'b1;
            end
            else if (rd_hit)
            begin
                ctrl.data_hit <= 1'b0;
            end
        end
    end

    // Read data is captured on the read strobe; other addresses read as zero.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata <= 16'h0000;
        end
        else if (reg_req.rd)
        begin
            reg_rdata <= sel ? ctrl : 16'h0000;
        end
    end

    // Pulse burst: one pulse now, the rest spaced by a fixed gap.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            burst_left <= 3'h0;
            gap_cnt <= 8'h00;
            detect_pulse_tx <= 1'b0;
        end
        else if (power_up_start)
        begin
            burst_left <= (ctrl.burst_dis ? BURST_SHORT : BURST_LONG) - 3'h1;
            gap_cnt <= PULSE_GAP_CYC;
            detect_pulse_tx <= 1'b1;
        end
        else if (burst_left != 3'h0 && gap_cnt == 8'h01)
        begin
            burst_left <= burst_left - 3'h1;
            gap_cnt <= PULSE_GAP_CYC;
            detect_pulse_tx <= 1'b1;
        end
        else
        begin
            detect_pulse_tx <= 1'b0;
            if (gap_cnt != 8'h00)
            begin
                gap_cnt <= gap_cnt - 8'h01;
            end
        end
    end

endmodule

`default_nettype wire

/* energy_detect_pkg.sv */
package energy_detect_pkg;

    // Management register address of the control register.
    localparam logic [4:0] EDC_ADDR = 5'h1D;

    // Field positions inside the 16-bit control register.
    localparam int BIT_ENABLE = 15;
    localparam int BIT_AUTO_WAKE = 14;
    localparam int BIT_AUTO_SLEEP = 13;
    localparam int BIT_MANUAL = 12;
    localparam int BIT_BURST_DIS = 11;
    localparam int BIT_PWR_STATE = 10;
    localparam int BIT_ERR_HIT = 9;
    localparam int BIT_DATA_HIT = 8;

    // Reset values of the writable fields, and the saturation value of the event counters.
    localparam logic RST_ENABLE = 1'b0;
    localparam logic RST_AUTO_WAKE = 1'b1;
    localparam logic RST_AUTO_SLEEP = 1'b1;
    localparam logic RST_BURST_DIS = 1'b0;
    localparam logic [3:0] RST_ERR_THRESH = 4'h1;
    localparam logic [3:0] RST_DATA_THRESH = 4'h1;
    localparam logic [3:0] COUNT_MAX = 4'hF;

    // Pulse burst on power-up.
    localparam logic [2:0] BURST_LONG = 3'h4;
    localparam logic [2:0] BURST_SHORT = 3'h1;
    localparam logic [7:0] PULSE_GAP_CYC = 8'h10;

    // Quiet time after which the event counters fall back to zero.
    localparam longint CLK_HZ = 50000000;
    localparam longint IDLE_RESET_S = 2;
    localparam longint IDLE_RESET_CYC = IDLE_RESET_S * CLK_HZ;
    localparam int IDLE_W = 28;

    typedef struct packed {
        logic enable;
        logic auto_wake;
        logic auto_sleep;
        logic manual;
        logic burst_dis;
        logic pwr_state;
        logic err_hit;
        logic data_hit;
        logic [3:0] err_thresh;
        logic [3:0] data_thresh;
    } energy_detect_control_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic data_event;
        logic error_event;
        logic energy_present;
    } line_events_t;

endpackage

/* energy_detect_power_control_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module energy_detect_power_control_sva
    import energy_detect_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Register access and line events
    input wire reg_req_t reg_req,
    input wire logic [15:0] reg_rdata,
    input wire line_events_t line_ev,
    // Power sequencing
    input wire logic power_up_start,
    input wire logic power_down_start,
    input wire logic detect_pulse_tx
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    logic st;
    logic [7:0] thr;
    logic rd_ctl;
    logic next_st;
    logic [2:0] mode;
    assign rd_ctl = reg_req.rd && reg_req.addr == EDC_ADDR;
    // The state seen by a read at this edge already includes a start pulse of this cycle.
    assign next_st = power_up_start | (st & ~power_down_start);
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            st <= 1'b0;
        else
            st <= next_st;
    end
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            thr <= {RST_ERR_THRESH, RST_DATA_THRESH};
        else if (reg_req.wr && reg_req.addr == EDC_ADDR)
            thr <= reg_req.wdata[7:0];
    end
    // Shadow of enable, automatic wake and automatic sleep, in that order.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            mode <= {RST_ENABLE, RST_AUTO_WAKE, RST_AUTO_SLEEP};
        else if (reg_req.wr && reg_req.addr == EDC_ADDR)
            mode <= reg_req.wdata[BIT_ENABLE:BIT_AUTO_SLEEP];
    end
    chk_start_exclusive: assert property (!(power_up_start && power_down_start))
        else $error("both start pulses high");
    chk_start_width: assert property (power_up_start |=> !power_up_start)
        else $error("power up start pulse too long");
    chk_down_width: assert property (power_down_start |=> !power_down_start)
        else $error("power down start pulse too long");
    chk_auto_sleep: assert property ((mode[2] && mode[0] && next_st &&
        !line_ev.energy_present) |=> power_down_start)
        else $error("no power down without line energy");
    chk_manual_toggle: assert property ((reg_req.wr && reg_req.addr == EDC_ADDR &&
        reg_req.wdata[BIT_MANUAL]) |-> ##2 (power_up_start || power_down_start))
        else $error("manual write gave no start");
    chk_burst_first: assert property (power_up_start |=> detect_pulse_tx)
        else $error("no pulse after power up");
    chk_pulse_single: assert property (detect_pulse_tx |=> !detect_pulse_tx)
        else $error("detect pulse too long");
    chk_err_thresh: assert property (rd_ctl |=> reg_rdata[7:4] == $past(thr[7:4]))
        else $error("error threshold readback wrong");
    chk_data_thresh: assert property (rd_ctl |=> reg_rdata[3:0] == $past(thr[3:0]))
        else $error("data threshold readback wrong");
    chk_state_read: assert property (rd_ctl |=> reg_rdata[BIT_PWR_STATE] == $past(next_st))
        else $error("power state readback wrong");
endmodule
bind energy_detect_power_control energy_detect_power_control_sva u_chk (.sys_clk(sys_clk),
    .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata), .line_ev(line_ev),
    .power_up_start(power_up_start), .power_down_start(power_down_start),
    .detect_pulse_tx(detect_pulse_tx));
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
    import energy_detect_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    reg_req_t reg_req = '0;
    line_events_t line_ev = '0;
    logic [15:0] reg_rdata;
    logic power_up_start;
    logic power_down_start;
    logic detect_pulse_tx;
    logic rd_d = 1'b0;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    logic [15:0] r;
    int fail_count = 0;
    int cmp_count = 0;
    int ups = 0;
    int downs = 0;
    int pulses = 0;
    always #10 sys_clk = ~sys_clk;
    // A short idle limit keeps the counter-clear check to a few dozen cycles.
    energy_detect_power_control #(.IDLE_RESET_CYCLES(IDLE_W'(50))) u_dut (.sys_clk(sys_clk),
        .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata), .line_ev(line_ev),
        .power_up_start(power_up_start), .power_down_start(power_down_start),
        .detect_pulse_tx(detect_pulse_tx));
    always @(posedge sys_clk)
    begin
        if (power_up_start === 1'b1) ups++;
        if (power_down_start === 1'b1) downs++;
        if (detect_pulse_tx === 1'b1) pulses++;
        if (rd_d)
        begin
            e = exp_q.pop_front();
            `CHK(reg_rdata, e)
        end
        rd_d <= reg_req.rd;
    end
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wr(input logic [15:0] d);
        @(negedge sys_clk);
        reg_req <= '{1'b1, 1'b0, EDC_ADDR, d};
        idle(1);
        reg_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] x);
        @(negedge sys_clk);
        exp_q.push_back(x);
        reg_req <= '{1'b0, 1'b1, a, 16'h0000};
        idle(1);
        reg_req.rd <= 1'b0;
    endtask
    task automatic ev(input int n, input logic err);
        repeat (n)
        begin
            @(negedge sys_clk);
            line_ev <= '{~err, err, line_ev.energy_present};
            idle(1);
            line_ev[2:1] <= 2'b00;
        end
    endtask
    initial
    begin
        #1000000;
        fail_count++;
        print_verdict();
    end
    initial
    begin
        r = $urandom(32'h2D188C24);
        idle(2);
        rst_b <= 1'b1;
        rd(EDC_ADDR, 16'h6011);
        rd(5'h00, 16'h0000);
        $display("test reset done");
        r = {8'h00, 8'($urandom)};
        wr(16'h6700 | r);
        rd(EDC_ADDR, 16'h6000 | r);
        $display("test fields done");
        wr(16'h1000 | r);
        idle(70);
        `CHK(ups, 1)
        `CHK(pulses, 4)
        rd(EDC_ADDR, 16'h0400 | r);
        wr(16'h1800 | r);
        idle(4);
        wr(16'h1800 | r);
        idle(70);
        `CHK(pulses, 5)
        rd(EDC_ADDR, 16'h0C00 | r);
        wr(16'h1000 | r);
        idle(4);
        `CHK(downs, 2)
        $display("test manual done");
        line_ev.energy_present <= 1'b1;
        wr(16'hE023); // Enable with automatic wake and sleep; error threshold 2, data threshold 3.
        ev(2, 1'b1);
        idle(4);
        `CHK(ups, 2)
        ev(3, 1'b0);
        idle(4);
        `CHK(ups, 3)
        rd(EDC_ADDR, 16'hE723);
        rd(EDC_ADDR, 16'hE423);
        $display("test wake done");
        line_ev.energy_present <= 1'b0;
        idle(3);
        `CHK(downs, 3)
        rd(EDC_ADDR, 16'hE023);
        $display("test sleep done");
        line_ev.energy_present <= 1'b1;
        ev(2, 1'b0);
        idle(60);
        ev(1, 1'b0);
        idle(4);
        `CHK(ups, 3)
        ev(2, 1'b0);
        idle(4);
        `CHK(ups, 4)
        $display("test idle done");
        wr(16'h6023);
        line_ev.energy_present <= 1'b0;
        ev(3, 1'b0);
        idle(4);
        `CHK(downs, 3)
        $display("test disable done");
        print_verdict();
    end
endmodule
`default_nettype wire
